// ==== logic/ostsel_delay.sv ====
`timescale 1ns/1ps
`default_nettype none
// per-terminal on/off delay and polarity
module ostsel_delay
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic status_i,
   input wire logic [ostsel_pkg::DELAY_W-1:0] on_delay_i,
   input wire logic [ostsel_pkg::DELAY_W-1:0] off_delay_i,
   input wire logic polarity_i,
   output logic term_o
);
   logic state;
   logic [ostsel_pkg::DELAY_W-1:0] cnt;
   logic [ostsel_pkg::DELAY_W-1:0] target;
   assign target = status_i ? on_delay_i : off_delay_i;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         cnt <= '0;
      else if (status_i == state)
         cnt <= '0;
      else if (tick_i && cnt < ostsel_pkg::DELAY_MAX)
         cnt <= cnt + 1'b1;
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         state <= 1'b0;
      else if (status_i != state && cnt >= target)
         state <= status_i;
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         term_o <= 1'b0;
      else
         term_o <= state ^ polarity_i;
   end
   AST_ZERO_DELAY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (status_i && !state && on_delay_i == '0) |=> state)
      else $error("zero on delay not immediate");
   AST_HOLD_DELAY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (status_i != state && cnt < target) |=> $stable(state))
      else $error("output changed before its delay");
   AST_POLARITY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ##1 term_o == ($past(state) ^ $past(polarity_i)))
      else $error("polarity mismatch");
endmodule : ostsel_delay
`default_nettype wire

// ==== logic/ostsel_level_det.sv ====
`timescale 1ns/1ps
`default_nettype none
// frequency level detector with hysteresis
module ostsel_level_det
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [ostsel_pkg::FREQ_W-1:0] freq_i,
   input wire logic [ostsel_pkg::FREQ_W-1:0] level_i,
   input wire logic [ostsel_pkg::PCT_W-1:0] hyst_i,
   output logic det_o
);
   logic [ostsel_pkg::FREQ_W+ostsel_pkg::PCT_W-1:0] prod;
   logic [ostsel_pkg::FREQ_W-1:0] hyst_freq;
   logic [ostsel_pkg::FREQ_W-1:0] off_level;
   assign prod = level_i * hyst_i;
   assign hyst_freq = ostsel_pkg::FREQ_W'(prod / ostsel_pkg::PCT_FULL);
   assign off_level = (hyst_freq > level_i) ? '0 : level_i - hyst_freq;
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         det_o <= 1'b0;
      else if (freq_i > level_i)
         det_o <= 1'b1;
      else if (freq_i < off_level)
         det_o <= 1'b0;
   end
   AST_LEVEL_ON: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (freq_i > level_i) |=> det_o)
      else $error("level detector missed rising level");
   AST_LEVEL_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (freq_i < off_level && freq_i <= level_i) |=> !det_o)
      else $error("level detector missed falling level");
endmodule : ostsel_level_det
`default_nettype wire

// ==== logic/ostsel_pkg.sv ====
package ostsel_pkg;
   localparam int FREQ_W = 16;
   localparam int CNT_W = 32;
   localparam int TEMP_W = 12;
   localparam int CODE_W = 6;
   localparam int PCT_W = 10;
   // hysteresis in tenths of a percent
   localparam logic [PCT_W-1:0] HYST_RESET = 10'h032;
   localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
   localparam int CLK_HZ = 125000000;
   localparam int PULSE_MS = 250;
   localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int DELAY_W = 15;
   localparam logic [DELAY_W-1:0] DELAY_MAX = 15'h7530;
   localparam logic [CODE_W-1:0] SEL_LOW_RUN = 6'h08;
   localparam logic [CODE_W-1:0] SEL_LOW_HOLD = 6'h09;
   localparam logic [CODE_W-1:0] SEL_REVERSE = 6'h0A;
   localparam logic [CODE_W-1:0] SEL_ZERO_RUN = 6'h0B;
   localparam logic [CODE_W-1:0] SEL_ZERO_HOLD = 6'h0C;
   localparam logic [CODE_W-1:0] SEL_SET_CNT = 6'h0D;
   localparam logic [CODE_W-1:0] SEL_DES_CNT = 6'h0E;
   localparam logic [CODE_W-1:0] SEL_LENGTH = 6'h0F;
   localparam logic [CODE_W-1:0] SEL_SEQ_DONE = 6'h10;
   localparam logic [CODE_W-1:0] SEL_LEVEL_ONE = 6'h11;
   localparam logic [CODE_W-1:0] SEL_LEVEL_TWO = 6'h12;
   localparam logic [CODE_W-1:0] SEL_FREQ_REACH = 6'h13;
   localparam logic [CODE_W-1:0] SEL_COMM = 6'h14;
   localparam logic [CODE_W-1:0] SEL_ANY_FREQ_TWO = 6'h15;
   localparam logic [CODE_W-1:0] SEL_CUR_ONE = 6'h16;
   localparam logic [CODE_W-1:0] SEL_CUR_TWO = 6'h17;
   localparam logic [CODE_W-1:0] SEL_MOD_TEMP = 6'h18;
   localparam logic [CODE_W-1:0] SEL_TIMING = 6'h19;
   localparam logic [CODE_W-1:0] SEL_ZERO_CUR = 6'h1A;
   localparam logic [CODE_W-1:0] SEL_CUR_LIMIT = 6'h1B;
   localparam logic [CODE_W-1:0] SEL_UNDER_VOLT = 6'h1C;
   localparam logic [CODE_W-1:0] SEL_DRV_OVL_WARN = 6'h1D;
   localparam logic [CODE_W-1:0] SEL_MOTOR_HOT = 6'h1E;
   localparam logic [CODE_W-1:0] SEL_MOTOR_OVL = 6'h1F;
endpackage : ostsel_pkg

// ==== logic/ostsel_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - code 8: lower limit, off at stop
// - code 9: lower limit, held at stop
// - code 10: on while reverse running
// - code 11: zero frequency running, off stopped
// - code 12: zero frequency, on when stopped
// - code 13: count reaches set target
// - code 14: count reaches designated target
// - code 15: length exceeds setpoint
// - code 16: 250 ms pulse per sequence
// - codes 17,18: level detectors one, two
// - code 19: frequency reached window
// - code 20: terminal commanded by communication
// - code 21: second any-frequency comparator
// - codes 22,23: current reached comparators
// - code 24: heatsink reaches module threshold
// - code 25: timing enabled and reached
// - codes 26,27: zero current, current limit
// - code 28: on during under-voltage
// - code 29: drive overload pre-warning
// - code 30: motor temperature reaches threshold
// - code 31: motor overload judged
// - level detector hysteresis on/off
// - separate on and off delays
// - polarity bit inverts output sense
module ostsel_top
#(
   parameter int N_TERM = 9,
   parameter int PULSE_CYCLES = ostsel_pkg::PULSE_CYCLES,
   parameter int TICK_CYCLES = ostsel_pkg::TICK_CYCLES
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic running_i,
   input wire logic reverse_i,
   input wire logic under_volt_i,
   input wire logic [ostsel_pkg::FREQ_W-1:0] run_freq_i,
   input wire logic [ostsel_pkg::FREQ_W-1:0] lower_limit_i,
   input wire logic [ostsel_pkg::CNT_W-1:0] pulse_count_i,
   input wire logic [ostsel_pkg::CNT_W-1:0] set_count_target_i,
   input wire logic [ostsel_pkg::CNT_W-1:0] designated_count_target_i,
   input wire logic [ostsel_pkg::CNT_W-1:0] actual_length_i,
   input wire logic [ostsel_pkg::CNT_W-1:0] length_setpoint_i,
   input wire logic seq_cycle_done_i,
   input wire logic [ostsel_pkg::FREQ_W-1:0] level_one_threshold_i,
   input wire logic [ostsel_pkg::PCT_W-1:0] level_one_hysteresis_i,
   input wire logic [ostsel_pkg::FREQ_W-1:0] level_two_threshold_i,
   input wire logic [ostsel_pkg::PCT_W-1:0] level_two_hysteresis_i,
   input wire logic freq_reached_i,
   input wire logic [N_TERM-1:0] comm_out_i,
   input wire logic any_freq_two_i,
   input wire logic current_one_i,
   input wire logic current_two_i,
   input wire logic [ostsel_pkg::TEMP_W-1:0] heatsink_temp_reading_i,
   input wire logic [ostsel_pkg::TEMP_W-1:0] module_temp_threshold_i,
   input wire logic timing_function_enable_i,
   input wire logic timing_reached_i,
   input wire logic zero_current_i,
   input wire logic current_limit_i,
   input wire logic drive_overload_warn_i,
   input wire logic [ostsel_pkg::TEMP_W-1:0] motor_temp_monitor_i,
   input wire logic [ostsel_pkg::TEMP_W-1:0] motor_overheat_threshold_i,
   input wire logic motor_overload_i,
   input wire logic [N_TERM*ostsel_pkg::CODE_W-1:0] func_sel_i,
   input wire logic [N_TERM*ostsel_pkg::DELAY_W-1:0] on_delay_i,
   input wire logic [N_TERM*ostsel_pkg::DELAY_W-1:0] off_delay_i,
   input wire logic [N_TERM-1:0] output_polarity_select_i,
   output logic [N_TERM-1:0] term_o,
   output logic level_one_o,
   output logic level_two_o
);
   logic low_reached;
   logic zero_freq;
   logic set_cnt_hit;
   logic des_cnt_hit;
   logic length_hit;
   logic mod_hot;
   logic motor_hot;
   logic seq_pulse;
   logic [31:0] pulse_cnt;
   logic [31:0] tick_cnt;
   logic tick;
   logic [N_TERM-1:0] status;

   // registered comparators keep the mux path short
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         low_reached <= 1'b0;
         zero_freq <= 1'b0;
         set_cnt_hit <= 1'b0;
         des_cnt_hit <= 1'b0;
         length_hit <= 1'b0;
         mod_hot <= 1'b0;
         motor_hot <= 1'b0;
      end
      else
      begin
         low_reached <= run_freq_i >= lower_limit_i;
         zero_freq <= run_freq_i == '0;
         set_cnt_hit <= pulse_count_i >= set_count_target_i;
         des_cnt_hit <= pulse_count_i >= designated_count_target_i;
         length_hit <= actual_length_i > length_setpoint_i;
         mod_hot <= heatsink_temp_reading_i >= module_temp_threshold_i;
         motor_hot <= motor_temp_monitor_i >= motor_overheat_threshold_i;
      end
   end

   // fixed-width pulse, retriggered by each completion
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         pulse_cnt <= '0;
      else if (seq_cycle_done_i)
         pulse_cnt <= 32'(PULSE_CYCLES);
      else if (pulse_cnt != '0)
         pulse_cnt <= pulse_cnt - 32'h00000001;
   end
   assign seq_pulse = pulse_cnt != '0;

   // 0.1 s tick for the delay counters
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
         tick_cnt <= '0;
      else if (tick_cnt == 32'(TICK_CYCLES - 1))
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + 32'h00000001;
   end
   assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

   ostsel_level_det u_level_one
   (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .freq_i(run_freq_i),
      .level_i(level_one_threshold_i),
      .hyst_i(level_one_hysteresis_i),
      .det_o(level_one_o)
   );
   ostsel_level_det u_level_two
   (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .freq_i(run_freq_i),
      .level_i(level_two_threshold_i),
      .hyst_i(level_two_hysteresis_i),
      .det_o(level_two_o)
   );

   genvar g;
   generate
      for (g = 0; g < N_TERM; g++)
      begin : g_term
         logic [ostsel_pkg::CODE_W-1:0] code;
         assign code = func_sel_i[g*ostsel_pkg::CODE_W +: ostsel_pkg::CODE_W];
         always_comb
         begin
            unique case (code)
               ostsel_pkg::SEL_LOW_RUN: status[g] = running_i && low_reached;
               ostsel_pkg::SEL_LOW_HOLD: status[g] = !running_i || low_reached;
               ostsel_pkg::SEL_REVERSE: status[g] = running_i && reverse_i;
               ostsel_pkg::SEL_ZERO_RUN: status[g] = running_i && zero_freq;
               ostsel_pkg::SEL_ZERO_HOLD: status[g] = !running_i || zero_freq;
               ostsel_pkg::SEL_SET_CNT: status[g] = set_cnt_hit;
               ostsel_pkg::SEL_DES_CNT: status[g] = des_cnt_hit;
               ostsel_pkg::SEL_LENGTH: status[g] = length_hit;
               ostsel_pkg::SEL_SEQ_DONE: status[g] = seq_pulse;
               ostsel_pkg::SEL_LEVEL_ONE: status[g] = level_one_o;
               ostsel_pkg::SEL_LEVEL_TWO: status[g] = level_two_o;
               ostsel_pkg::SEL_FREQ_REACH: status[g] = freq_reached_i;
               ostsel_pkg::SEL_COMM: status[g] = comm_out_i[g];
               ostsel_pkg::SEL_ANY_FREQ_TWO: status[g] = any_freq_two_i;
               ostsel_pkg::SEL_CUR_ONE: status[g] = current_one_i;
               ostsel_pkg::SEL_CUR_TWO: status[g] = current_two_i;
               ostsel_pkg::SEL_MOD_TEMP: status[g] = mod_hot;
               ostsel_pkg::SEL_TIMING:
                  status[g] = timing_function_enable_i && timing_reached_i;
               ostsel_pkg::SEL_ZERO_CUR: status[g] = zero_current_i;
               ostsel_pkg::SEL_CUR_LIMIT: status[g] = current_limit_i;
               ostsel_pkg::SEL_UNDER_VOLT: status[g] = under_volt_i;
               ostsel_pkg::SEL_DRV_OVL_WARN: status[g] = drive_overload_warn_i;
               ostsel_pkg::SEL_MOTOR_HOT: status[g] = motor_hot;
               ostsel_pkg::SEL_MOTOR_OVL: status[g] = motor_overload_i;
               default: status[g] = 1'b0;
            endcase
         end

         ostsel_delay u_delay
         (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .tick_i(tick),
            .status_i(status[g]),
            .on_delay_i(on_delay_i[g*ostsel_pkg::DELAY_W +: ostsel_pkg::DELAY_W]),
            .off_delay_i(off_delay_i[g*ostsel_pkg::DELAY_W +: ostsel_pkg::DELAY_W]),
            .polarity_i(output_polarity_select_i[g]),
            .term_o(term_o[g])
         );

         AST_LOW_STOP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_LOW_RUN && !running_i) |-> !status[g])
            else $error("lower limit status on while stopped");
         AST_ZERO_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_ZERO_HOLD && !running_i) |-> status[g])
            else $error("zero speed status off while stopped");
         AST_TIMING_GATE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_TIMING && !timing_function_enable_i)
            |-> !status[g])
            else $error("timing status on while disabled");
         AST_UNLISTED: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code < ostsel_pkg::SEL_LOW_RUN || code > ostsel_pkg::SEL_MOTOR_OVL)
            |-> !status[g])
            else $error("unlisted code drove a status");
         AST_LOW_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_LOW_HOLD && !running_i) |-> status[g])
            else $error("lower limit status off while stopped");
         AST_ZERO_STOP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_ZERO_RUN && !running_i) |-> !status[g])
            else $error("zero speed status on while stopped");
         AST_LEVEL_SEL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_LEVEL_ONE) |-> (status[g] == level_one_o))
            else $error("level detector one not routed");
         AST_COMM: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_COMM) |-> (status[g] == comm_out_i[g]))
            else $error("communication command not routed");
         AST_UNDER_VOLT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
            (code == ostsel_pkg::SEL_UNDER_VOLT && under_volt_i) |-> status[g])
            else $error("under-voltage status missing");
      end
   endgenerate

   sequence seq_done_seen;
      seq_cycle_done_i;
   endsequence
   sequence pulse_runs;
      seq_pulse [*8];
   endsequence
   AST_SEQ_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      seq_done_seen |=> pulse_runs)
      else $error("sequence pulse too short");
   AST_SEQ_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      seq_cycle_done_i |=> pulse_cnt == 32'(PULSE_CYCLES))
      else $error("sequence pulse width wrong");
   AST_LENGTH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (actual_length_i > length_setpoint_i) |=> length_hit)
      else $error("length compare missed");
   AST_SET_CNT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (pulse_count_i < set_count_target_i) |=> !set_cnt_hit)
      else $error("set count compare early");
   AST_DES_CNT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (pulse_count_i >= designated_count_target_i) |=> des_cnt_hit)
      else $error("designated count compare missed");
   AST_MOD_TEMP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (heatsink_temp_reading_i >= module_temp_threshold_i) |=> mod_hot)
      else $error("module temperature compare missed");
   AST_MOTOR_HOT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (motor_temp_monitor_i >= motor_overheat_threshold_i) |=> motor_hot)
      else $error("motor temperature compare missed");
   AST_SEQ_END: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (pulse_cnt == 32'h00000001 && !seq_cycle_done_i) |=> !seq_pulse)
      else $error("sequence pulse too long");
   AST_TICK_ONE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      tick |=> !tick)
      else $error("delay tick wider than one cycle");
endmodule : ostsel_top
`default_nettype wire

// ==== verification/ostsel_load.sv ====
`timescale 1ns/1ps
`default_nettype none
// relay and open-collector loads: each contact follows its terminal one clock later
module ostsel_load
#(
   parameter int N_TERM = 9
)
(
   input wire logic ref_clk_i,
   input wire logic [N_TERM-1:0] term_i,
   output logic [N_TERM-1:0] conduct_o
);
   always_ff @(posedge ref_clk_i)
   begin
      conduct_o <= term_i;
   end
endmodule : ostsel_load
`default_nettype wire

// ==== verification/ostsel_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ostsel_top_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic running = 1'b0, reverse = 1'b0, uv = 1'b0, seq = 1'b0, frq = 1'b0, any2 = 1'b0;
   logic c1 = 1'b0, c2 = 1'b0, tmen = 1'b0, tmr = 1'b0, zc = 1'b0, cl = 1'b0;
   logic dow = 1'b0, mo = 1'b0;
   logic [15:0] freq = 16'h0000, lower = 16'h0000;
   logic [31:0] pc = 32'h0, sct = 32'h0, dct = 32'h0, len = 32'h0, lsp = 32'h0;
   logic [11:0] hs = 12'h000, mt = 12'h000, mm = 12'h000, mth = 12'h000;
   logic [8:0] comm = 9'h000, pol = 9'h000, term, conduct;
   logic [53:0] fsel = 54'h0;
   logic [134:0] ond = 135'h0, offd = 135'h0;
   logic l1, l2;
   logic [15:0] lv1 = 16'h03E8, lv2 = 16'h03E8;
   logic [9:0] hy1 = 10'h032, hy2 = 10'h064;
   logic [31:0] r, r2, r3, r4;
   int seed = 53;
   int miscompares = 0;
   int num_checks = 0;
   int m1 = 0, m2 = 0;
   int o1 = 0, o2 = 0;

   always #4 clk = ~clk;

   ostsel_top #(.N_TERM(9), .PULSE_CYCLES(20), .TICK_CYCLES(4)) dut (
      .ref_clk_i(clk), .rst_n_i(rst_n), .running_i(running), .reverse_i(reverse),
      .under_volt_i(uv), .run_freq_i(freq), .lower_limit_i(lower), .pulse_count_i(pc),
      .set_count_target_i(sct), .designated_count_target_i(dct), .actual_length_i(len),
      .length_setpoint_i(lsp), .seq_cycle_done_i(seq), .level_one_threshold_i(lv1),
      .level_one_hysteresis_i(hy1), .level_two_threshold_i(lv2),
      .level_two_hysteresis_i(hy2), .freq_reached_i(frq), .comm_out_i(comm),
      .any_freq_two_i(any2), .current_one_i(c1), .current_two_i(c2),
      .heatsink_temp_reading_i(hs), .module_temp_threshold_i(mt),
      .timing_function_enable_i(tmen), .timing_reached_i(tmr), .zero_current_i(zc),
      .current_limit_i(cl), .drive_overload_warn_i(dow), .motor_temp_monitor_i(mm),
      .motor_overheat_threshold_i(mth), .motor_overload_i(mo), .func_sel_i(fsel),
      .on_delay_i(ond), .off_delay_i(offd), .output_polarity_select_i(pol),
      .term_o(term), .level_one_o(l1), .level_two_o(l2));

   ostsel_load #(.N_TERM(9)) load (.ref_clk_i(clk), .term_i(term), .conduct_o(conduct));

   task automatic summarize();
      if (miscompares == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   // status picked by each code, code 16 and unlisted codes inactive
   function automatic logic st(int c, int g);
      case (c)
         8: return running && freq >= lower;
         9: return !running || freq >= lower;
         10: return running && reverse;
         11: return running && freq == 16'h0000;
         12: return !running || freq == 16'h0000;
         13: return pc >= sct;
         14: return pc >= dct;
         15: return len > lsp;
         17: return m1 != 0;
         18: return m2 != 0;
         19: return frq;
         20: return comm[g];
         21: return any2;
         22: return c1;
         23: return c2;
         24: return hs >= mt;
         25: return tmen && tmr;
         26: return zc;
         27: return cl;
         28: return uv;
         29: return dow;
         30: return mm >= mth;
         31: return mo;
         default: return 1'b0;
      endcase
   endfunction : st

   task automatic wt(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wt

   task automatic rnd(int i);
      r = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      r4 = $random(seed);
      {mo, dow, cl, zc, tmr, tmen, c2, c1, any2, frq, uv, reverse, running} = r[12:0];
      freq = (r[16:13] == 4'h0) ? 16'h0000 : 16'h0384 + {8'h00, r[24:17]};
      lower = 16'h0384 + {8'h00, r2[7:0]};
      pc = {24'h0, r2[15:8]};
      sct = {24'h0, r2[23:16]};
      dct = {24'h0, r2[31:24]};
      len = {28'h0, r3[3:0]};
      lsp = {28'h0, r3[7:4]};
      {mth, mm} = {4'h0, r3[23:20], 4'h0, r3[19:16]};
      {mt, hs} = {4'h0, r3[15:12], 4'h0, r3[11:8]};
      comm = r4[8:0];
      pol = r4[17:9];
      lv1 = 16'h0384 + {8'h00, r3[31:24]};
      lv2 = 16'h0384 + {9'h000, r[31:25]};
      hy1 = {4'h0, r4[23:18]};
      hy2 = {4'h0, r4[29:24]};
      for (int g = 0; g < 9; g++)
         fsel[g*6+:6] = 6'((i * 7 + g) % 64);
      wt(6);
      // off level is the threshold less its hysteresis share in tenths of a percent
      o1 = 32'(lv1) - 32'(lv1) * 32'(hy1) / 1000;
      o2 = 32'(lv2) - 32'(lv2) * 32'(hy2) / 1000;
      if (freq > lv1)
         m1 = 1;
      else if (32'(freq) < o1)
         m1 = 0;
      if (freq > lv2)
         m2 = 1;
      else if (32'(freq) < o2)
         m2 = 0;
      for (int g = 0; g < 9; g++)
         chk("term", 32'(term[g]), 32'(st((i * 7 + g) % 64, g) ^ pol[g]));
      chk("level_one", 32'(l1), 32'(m1));
      chk("level_two", 32'(l2), 32'(m2));
   endtask : rnd

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial
   begin
      wt(4);
      chk("reset_term", 32'(term), 32'h0);
      rst_n = 1'b1;
      for (int i = 0; i < 64; i++)
         rnd(i);
      fsel = 54'h0;
      fsel[5:0] = 6'h10;
      pol = 9'h000;
      comm = 9'h000;
      wt(25);
      seq = 1'b1;
      wt(1);
      seq = 1'b0;
      wt(4);
      chk("pulse_on", 32'(term[0]), 32'h1);
      wt(6);
      seq = 1'b1;
      wt(1);
      seq = 1'b0;
      wt(18);
      chk("pulse_retrig", 32'(term[0]), 32'h1);
      chk("load", 32'(conduct[0]), 32'h1);
      wt(10);
      chk("pulse_off", 32'(term[0]), 32'h0);
      fsel[11:6] = 6'h14;
      ond[29:15] = 15'h0003;
      offd[29:15] = 15'h0002;
      wt(12);
      comm[1] = 1'b1;
      wt(6);
      chk("on_wait", 32'(term[1]), 32'h0);
      wt(12);
      chk("on_done", 32'(term[1]), 32'h1);
      comm[1] = 1'b0;
      wt(4);
      chk("off_wait", 32'(term[1]), 32'h1);
      wt(12);
      chk("off_done", 32'(term[1]), 32'h0);
      summarize();
   end
endmodule : ostsel_top_tb
`default_nettype wire
